// [design/tsx_core.sv]
// Execution of table read/write, test-and-skip and xor-literal
//
// The Avalon-MM register port and the address map were decided locally.
`timescale 1ns/1ns
`default_nettype none
`include "tsx_params.svh"
module tsx_core
  import tsx_pkg::*;
#(
  parameter int PTR_W  = `TSX_PTR_W,
  parameter int HOLD_N = `TSX_HOLD_N
)(
  input  wire logic                   ref_clk,
  input  wire logic                   reset_n,
  input  wire logic [`TSX_ADDR_W-1:0] avs_address,
  input  wire logic                   avs_read,
  input  wire logic                   avs_write,
  input  wire logic [31:0]            avs_writedata,
  output logic      [31:0]            avs_readdata,
  output logic                        avs_waitrequest,
  output tsx_pkg::tsx_prog_req_t      prog_req,
  input  wire logic [15:0]            prog_rd_data,
  output tsx_pkg::tsx_file_req_t      file_req,
  input  wire logic [7:0]             file_rd_data,
  input  wire logic [11:0]            index_base,
  input  wire logic                   next_two_word,
  output logic                        skip_flush,
  output logic                        busy
);
  import tsx_pkg::*;

  tsx_state_t          state;
  tsx_instr_t          cur;
  logic [1:0]          qph;
  logic [1:0]          cyc;
  logic [1:0]          last_cyc;
  logic [PTR_W-1:0]    table_pointer;
  logic [7:0]          table_latch;
  logic [7:0]          work;
  logic [3:0]          bank_select_reg;
  logic                flag_z;
  logic                flag_n;
  logic                skip_seen;
  logic                ext_en;
  logic [7:0]          wr_copy;
  logic [7:0]          hold [HOLD_N];

  function automatic tsx_instr_t decode(input logic [15:0] op);
    tsx_instr_t d;
    d.kind = TSX_K_NONE;
    d.mode = tsx_ptr_mode_t'(op[1:0]);
    d.acc  = op[8];
    d.arg  = op[7:0];
    if (op[15:2] == `TSX_OPC_TBL)
      d.kind = TSX_K_TRD;
    else if (op[15:3] == 13'(`TSX_OPC_TBL >> 1) && op[`TSX_OPC_WR_BIT])
      d.kind = TSX_K_TWR;
    else if (op[15:9] == `TSX_OPC_TST)
      d.kind = TSX_K_TST;
    else if (op[15:8] == `TSX_OPC_XOR)
      d.kind = TSX_K_XOR;
    return d;
  endfunction : decode

  function automatic logic [PTR_W-1:0] ptr_step(
    input logic [PTR_W-1:0] p,
    input logic             down
  );
    ptr_step = down ? p - PTR_W'(1) : p + PTR_W'(1);
  endfunction : ptr_step

  // Bus handshake
  wire bus_req   = avs_read | avs_write;
  wire taken     = bus_req & ~avs_waitrequest;
  wire wr_taken  = avs_write & ~avs_waitrequest;
  // Writes wait out a running instruction so software and the
  // execution never drive the same register in one cycle
  wire wr_stall  = avs_write & (state != TSX_IDLE);
  wire grant     = bus_req & avs_waitrequest & ~wr_stall;
  wire hit_instr = avs_address == `TSX_OFS_INSTR;
  wire hit_work  = avs_address == `TSX_OFS_WORK;
  wire hit_ptr   = avs_address == `TSX_OFS_PTR;
  wire hit_latch = avs_address == `TSX_OFS_LATCH;
  wire hit_bank  = avs_address == `TSX_OFS_BANK;
  wire hit_stat  = avs_address == `TSX_OFS_STATUS;
  wire hit_ctrl  = avs_address == `TSX_OFS_CTRL;
  wire hit_hold  = (avs_address & `TSX_HOLD_MASK) == `TSX_OFS_HOLD;
  wire [2:0] hold_sel = avs_address[4:2];
  wire tsx_instr_t dec_in = decode(avs_writedata[15:0]);
  wire start     = wr_taken & hit_instr;

  // Phase strobes of the four-phase instruction cycle
  wire run     = state == TSX_RUN;
  wire q2      = run & (qph == `TSX_Q_READ);
  wire q3      = run & (qph == `TSX_Q_TEST);
  wire q4      = run & (qph == `TSX_Q_LAST);
  wire first_c = cyc == 2'h0;
  wire is_trd  = cur.kind == TSX_K_TRD;
  wire is_twr  = cur.kind == TSX_K_TWR;
  wire is_tbl  = is_trd | is_twr;
  wire is_tst  = cur.kind == TSX_K_TST;
  wire is_xor  = cur.kind == TSX_K_XOR;
  wire done    = q4 & (cyc == last_cyc);

  // Pointer motion: pre-increment lands before the access cycle,
  // post modes after it, so the access sees the right address
  wire pre_upd  = is_tbl & q4 & first_c & (cur.mode == TSX_M_PREINC);
  wire post_upd = is_tbl & q4 & ~first_c &
                  (cur.mode == TSX_M_POSTINC ||
                   cur.mode == TSX_M_POSTDEC);
  wire ptr_down = cur.mode == TSX_M_POSTDEC;

  // Operand address resolution for test-and-skip
  wire idx_mode = ext_en & ~cur.acc & (cur.arg <= `TSX_IDX_LIMIT);
  wire [11:0] idx_addr = index_base + {4'h0, cur.arg};
  wire [3:0] acc_bank = (cur.arg >= `TSX_ACC_SPLIT) ?
                        `TSX_ACC_HI_BANK : `TSX_ACC_LO_BANK;
  wire [11:0] acc_addr = {acc_bank, cur.arg};
  wire [11:0] bank_addr = {bank_select_reg, cur.arg};
  wire [11:0] opnd_addr = idx_mode ? idx_addr :
                          (cur.acc ? bank_addr : acc_addr);
  wire zero_hit = is_tst & first_c & q3 & (file_rd_data == 8'h00);
  wire [1:0] skip_len = next_two_word ? 2'h2 : 2'h1;

  wire [7:0] xor_res = work ^ cur.arg;
  wire [7:0] prog_byte = table_pointer[0] ?
                         prog_rd_data[15:8] : prog_rd_data[7:0];

  // Read multiplexer; unmapped addresses read as zero
  wire [31:0] status_word = {28'h0, state == TSX_RUN, skip_seen,
                             flag_n, flag_z};
  wire [31:0] rd_mux =
    hit_work  ? {24'h0, work} :
    hit_ptr   ? {{(32-PTR_W){1'b0}}, table_pointer} :
    hit_latch ? {24'h0, table_latch} :
    hit_bank  ? {28'h0, bank_select_reg} :
    hit_stat  ? status_word :
    hit_ctrl  ? {31'h0, ext_en} :
    hit_hold  ? {24'h0, hold[hold_sel]} :
    hit_instr ? {29'h0, cur.kind} : 32'h0;

  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      avs_waitrequest <= 1'b1;
      avs_readdata    <= 32'h0;
    end
    else if (grant)
    begin
      avs_waitrequest <= 1'b0;
      avs_readdata    <= rd_mux;
    end
    else
      avs_waitrequest <= 1'b1;
  end

  // Sequencer
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      state    <= TSX_IDLE;
      cur      <= '0;
      qph      <= 2'h0;
      cyc      <= 2'h0;
      last_cyc <= 2'h0;
    end
    else
    begin
      case (state)
        TSX_IDLE:
        begin
          if (start && dec_in.kind != TSX_K_NONE)
          begin
            state    <= TSX_RUN;
            cur      <= dec_in;
            qph      <= 2'h0;
            cyc      <= 2'h0;
            last_cyc <= (dec_in.kind == TSX_K_TRD ||
                         dec_in.kind == TSX_K_TWR) ?
                        `TSX_TBL_CYCLES - `TSX_ONE_CYCLE : 2'h0;
          end
        end
        TSX_RUN:
        begin
          qph <= qph + 2'h1;
          if (zero_hit)
            last_cyc <= skip_len;
          if (done)
            state <= TSX_IDLE;
          else if (q4)
            cyc <= cyc + 2'h1;
        end
        default:
          state <= TSX_IDLE;
      endcase
    end
  end

  // Table pointer
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
      table_pointer <= '0;
    else if (wr_taken && hit_ptr)
      table_pointer <= avs_writedata[PTR_W-1:0];
    else if (pre_upd)
      table_pointer <= ptr_step(table_pointer, 1'b0);
    else if (post_upd)
      table_pointer <= ptr_step(table_pointer, ptr_down);
  end

  // Program memory access in Q2 of the second cycle, byte in Q4
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
      prog_req <= '0;
    else
    begin
      prog_req.rd        <= is_trd & ~first_c & (qph == 2'h0) & run;
      prog_req.word_addr <= table_pointer[PTR_W-1:1];
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
      table_latch <= 8'h0;
    else if (wr_taken && hit_latch)
      table_latch <= avs_writedata[7:0];
    else if (is_trd && ~first_c && q4)
      table_latch <= prog_byte;
  end

  // Holding registers only; programming the array is elsewhere
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
      wr_copy <= 8'h0;
    else if (is_twr && ~first_c && q2)
      wr_copy <= table_latch;
  end

  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      for (int i = 0; i < HOLD_N; i++)
        hold[i] <= 8'hFF;
    end
    else if (is_twr && ~first_c && q4)
      hold[table_pointer[2:0]] <= wr_copy;
  end
  // The holding write above is the only store

  // Operand fetch for test-and-skip
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
      file_req <= '0;
    else
    begin
      file_req.rd   <= is_tst & first_c & (qph == 2'h0) & run;
      file_req.addr <= opnd_addr;
    end
  end

  // Skip flush covers the discarded word(s); flags untouched
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      skip_flush <= 1'b0;
      skip_seen  <= 1'b0;
    end
    else if (zero_hit)
    begin
      skip_flush <= 1'b1;
      skip_seen  <= 1'b1;
    end
    else if (start)
      skip_seen  <= 1'b0;
    else if (done)
      skip_flush <= 1'b0;
  end

  // Working register and the two flags the xor may touch
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      work   <= 8'h0;
      flag_z <= 1'b0;
      flag_n <= 1'b0;
    end
    else if (wr_taken && hit_work)
      work <= avs_writedata[7:0];
    else if (wr_taken && hit_stat)
    begin
      flag_z <= avs_writedata[`TSX_ST_Z];
      flag_n <= avs_writedata[`TSX_ST_N];
    end
    else if (is_xor && q4)
    begin
      work   <= xor_res;
      flag_z <= xor_res == 8'h00;
      flag_n <= xor_res[7];
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      bank_select_reg <= 4'h0;
      ext_en          <= 1'b0;
    end
    else if (wr_taken && hit_bank)
      bank_select_reg <= avs_writedata[3:0];
    else if (wr_taken && hit_ctrl)
      ext_en <= avs_writedata[`TSX_CTRL_EXT];
  end

  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
      busy <= 1'b0;
    else
      busy <= (start && dec_in.kind != TSX_K_NONE) | (run & ~done);
  end

endmodule : tsx_core
`default_nettype wire

// [design/tsx_params.svh]
// Offsets, field positions, opcodes and timing counts of the block
`ifndef TSX_PARAMS_SVH
`define TSX_PARAMS_SVH
`define TSX_ADDR_W      8
`define TSX_OFS_INSTR   8'h00
`define TSX_OFS_WORK    8'h04
`define TSX_OFS_PTR     8'h08
`define TSX_OFS_LATCH   8'h0C
`define TSX_OFS_BANK    8'h10
`define TSX_OFS_STATUS  8'h14
`define TSX_OFS_CTRL    8'h18
`define TSX_OFS_HOLD    8'h20
`define TSX_HOLD_MASK   8'hE3
`define TSX_PTR_W       21
`define TSX_FILE_AW     12
`define TSX_HOLD_N      8
`define TSX_OPC_TBL     14'h0002
`define TSX_OPC_WR_BIT  2
`define TSX_OPC_TST     7'h33
`define TSX_OPC_XOR     8'h0A
`define TSX_IDX_LIMIT   8'h5F
`define TSX_ACC_SPLIT   8'h60
`define TSX_ACC_HI_BANK 4'hF
`define TSX_ACC_LO_BANK 4'h0
`define TSX_ST_Z        0
`define TSX_ST_N        1
`define TSX_ST_SKIP     2
`define TSX_ST_BUSY     3
`define TSX_CTRL_EXT    0
`define TSX_TBL_CYCLES  2'h2
`define TSX_ONE_CYCLE   2'h1
`define TSX_Q_LAST      2'h3
`define TSX_Q_READ      2'h1
`define TSX_Q_TEST      2'h2
`endif

// [design/tsx_pkg.sv]
// Types shared by the table, skip and xor execution block
package tsx_pkg;
  typedef enum logic [0:0] {
    TSX_IDLE = 1'b0,
    TSX_RUN  = 1'b1
  } tsx_state_t;
  typedef enum logic [2:0] {
    TSX_K_NONE = 3'b000,
    TSX_K_TRD  = 3'b001,
    TSX_K_TWR  = 3'b010,
    TSX_K_TST  = 3'b011,
    TSX_K_XOR  = 3'b100
  } tsx_kind_t;
  typedef enum logic [1:0] {
    TSX_M_KEEP    = 2'b00,
    TSX_M_POSTINC = 2'b01,
    TSX_M_POSTDEC = 2'b10,
    TSX_M_PREINC  = 2'b11
  } tsx_ptr_mode_t;
  typedef struct packed {
    tsx_kind_t     kind;
    tsx_ptr_mode_t mode;
    logic          acc;
    logic [7:0]    arg;
  } tsx_instr_t;
  typedef struct packed {
    logic [19:0] word_addr;
    logic        rd;
  } tsx_prog_req_t;
  typedef struct packed {
    logic [11:0] addr;
    logic        rd;
  } tsx_file_req_t;
endpackage : tsx_pkg

// [testbench/tsx_mem_model.sv]
// Program memory and register file model facing the block
`timescale 1ns/1ns
`default_nettype none
module tsx_mem_model
  import tsx_pkg::*;
(
  input  wire logic                   ref_clk,
  input  wire tsx_pkg::tsx_prog_req_t prog_req,
  input  wire tsx_pkg::tsx_file_req_t file_req,
  output logic [15:0]                 prog_rd_data,
  output logic [7:0]                  file_rd_data
);
  logic        p_hold = 1'h0;
  // The block takes the byte two cycles after the request cycle
  logic        p_hold2 = 1'h0;
  logic        f_hold = 1'h0;
  logic [7:0]  p_addr = 8'h00;
  logic [11:0] f_addr = 12'h000;
  logic [7:0]  churn  = 8'h00;
  wire  [7:0]  p_sel  = prog_req.rd ? prog_req.word_addr[7:0] : p_addr;
  wire  [11:0] f_sel  = file_req.rd ? file_req.addr : f_addr;
  // Outside the answer window the lines churn so stale data cannot pass
  assign prog_rd_data = (prog_req.rd | p_hold | p_hold2) ? {~p_sel, p_sel}
                                                         : {churn, ~churn};
  assign file_rd_data = (file_req.rd | f_hold)
                        ? f_sel[7:0] ^ {2{f_sel[11:8]}} : churn;
  always_ff @(posedge ref_clk)
  begin
    p_hold <= prog_req.rd;
    p_hold2 <= p_hold;
    f_hold <= file_req.rd;
    if (prog_req.rd) p_addr <= prog_req.word_addr[7:0];
    if (file_req.rd) f_addr <= file_req.addr;
    churn <= churn + 8'h3B;
  end
endmodule : tsx_mem_model
`default_nettype wire

// [testbench/tsx_core_sva.sv]
// Port checks of the execution block
`timescale 1ns/1ns
`default_nettype none
module tsx_core_sva
  import tsx_pkg::*;
(
  input wire logic                   ref_clk,
  input wire logic                   reset_n,
  input wire logic                   avs_write,
  input wire logic                   avs_waitrequest,
  input wire tsx_pkg::tsx_prog_req_t prog_req,
  input wire tsx_pkg::tsx_file_req_t file_req,
  input wire logic                   skip_flush,
  input wire logic                   busy
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!reset_n);
  a_write_stall:
    assert property (avs_write && busy |-> avs_waitrequest)
    else $error("Write accepted during execution");
  a_prog_pulse:
    assert property (prog_req.rd |=> !prog_req.rd)
    else $error("Program read longer than one cycle");
  a_prog_tail:
    assert property (prog_req.rd |=> busy [*2] ##[1:3] !busy)
    else $error("Table read does not end after memory access");
  a_file_pulse:
    assert property (file_req.rd |=> !file_req.rd)
    else $error("Operand read longer than one cycle");
  a_busy_min:
    assert property ($rose(busy) |-> busy [*4])
    else $error("Instruction shorter than one cycle");
  a_busy_max:
    assert property ($rose(busy) |-> ##[4:12] !busy)
    else $error("Instruction longer than three cycles");
  a_flush_in_busy:
    assert property (skip_flush |-> busy)
    else $error("Flush outside an instruction");
  a_flush_end:
    assert property ($fell(skip_flush) |-> $fell(busy))
    else $error("Flush does not end with the instruction");
endmodule : tsx_core_sva
bind tsx_core tsx_core_sva tsx_core_sva_inst (.ref_clk(ref_clk),
  .reset_n(reset_n), .avs_write(avs_write),
  .avs_waitrequest(avs_waitrequest), .prog_req(prog_req),
  .file_req(file_req), .skip_flush(skip_flush), .busy(busy));
`default_nettype wire

// [testbench/testbench.sv]
// Self-checking bench for the table, skip and xor block
`timescale 1ns/1ns
`default_nettype none
`include "tsx_params.svh"
module testbench;
  import tsx_pkg::*;
  typedef struct {logic [15:0] op; logic [20:0] ptr;} tsx_row_t;
  typedef struct {logic a; logic [7:0] f; logic [3:0] bank;
    logic ext; logic two;} tsx_skip_t;
  logic          ref_clk = 1'h0;
  logic          reset_n = 1'h0;
  logic [7:0]    avs_address = 8'h00;
  logic          avs_read = 1'h0;
  logic          avs_write = 1'h0;
  logic [31:0]   avs_writedata = 32'h0;
  logic [31:0]   avs_readdata, q;
  logic          avs_waitrequest, skip_flush, busy, z;
  logic [11:0]   index_base = 12'h320;
  logic          next_two_word = 1'h0;
  logic [15:0]   prog_rd_data;
  logic [7:0]    file_rd_data, w;
  tsx_prog_req_t prog_req;
  tsx_file_req_t file_req;
  int            mismatches = 0;
  int            cmp_count = 0;
  int            bcnt = 0;
  int            scnt = 0;
  logic [11:0]   faddr, ea;
  logic [20:0]   pre, post;
  tsx_row_t rows [8] = '{'{16'h0008, 21'h00A356}, '{16'h0009, 21'h00A356},
    '{16'h000A, 21'h000000}, '{16'h000B, 21'h1FFFFF},
    '{16'h000C, 21'h000003}, '{16'h000D, 21'h000007},
    '{16'h000E, 21'h000000}, '{16'h000F, 21'h01389A}};
  tsx_skip_t sk [7] = '{'{1'h1, 8'h33, 4'h3, 1'h0, 1'h0},
    '{1'h1, 8'h12, 4'h2, 1'h1, 1'h0}, '{1'h0, 8'h10, 4'h5, 1'h0, 1'h0},
    '{1'h0, 8'hFF, 4'h5, 1'h0, 1'h1}, '{1'h0, 8'h13, 4'h5, 1'h1, 1'h0},
    '{1'h0, 8'h5F, 4'h5, 1'h1, 1'h1}, '{1'h0, 8'h60, 4'h5, 1'h1, 1'h0}};
  logic [7:0] ks [3] = '{8'hAF, 8'h1A, 8'h80};
  tsx_core tsx_core_inst (.ref_clk(ref_clk), .reset_n(reset_n),
    .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .prog_req(prog_req), .prog_rd_data(prog_rd_data),
    .file_req(file_req), .file_rd_data(file_rd_data),
    .index_base(index_base), .next_two_word(next_two_word),
    .skip_flush(skip_flush), .busy(busy));
  tsx_mem_model tsx_mem_model_inst (.ref_clk(ref_clk),
    .prog_req(prog_req), .file_req(file_req),
    .prog_rd_data(prog_rd_data), .file_rd_data(file_rd_data));
  initial forever #10 ref_clk = ~ref_clk;
  // Sampled on the falling edge, where registered outputs are settled
  always @(negedge ref_clk)
  begin
    if (busy === 1'h1) bcnt <= bcnt + 1;
    if (skip_flush === 1'h1) scnt <= scnt + 1;
    if (file_req.rd === 1'h1) faddr <= file_req.addr;
  end
  task close_out;
    if (mismatches == 0 && cmp_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : close_out
  task chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      mismatches++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task hang;
    mismatches++;
    close_out();
  endtask : hang
  task av(input logic wr_en, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge ref_clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr_en;
    avs_read <= ~wr_en;
    @(negedge ref_clk);
    for (n = 0; avs_waitrequest !== 1'h0; n++)
    begin
      if (n == 40) hang();
      @(negedge ref_clk);
    end
    @(posedge ref_clk);
    q = avs_readdata;
    avs_write <= 1'h0;
    avs_read <= 1'h0;
  endtask : av
  task wr(input logic [7:0] a, input logic [31:0] d);
    av(1'h1, a, d);
  endtask : wr
  task rd(input logic [7:0] a);
    av(1'h0, a, 32'h0);
  endtask : rd
  // Busy count is read only after a later access, once it has settled
  task run(input logic [15:0] op);
    int n;
    bcnt = 0;
    scnt = 0;
    av(1'h1, `TSX_OFS_INSTR, 32'(op));
    @(negedge ref_clk);
    for (n = 0; busy !== 1'h0; n++)
    begin
      if (n == 20) hang();
      @(negedge ref_clk);
    end
  endtask : run
  function automatic logic [7:0] pm(input logic [20:0] p);
    return p[0] ? ~p[8:1] : p[8:1];
  endfunction : pm
  initial
  begin
    repeat (8) @(posedge ref_clk);
    reset_n <= 1'h1;
    rd(`TSX_OFS_HOLD + 8'h14);
    chk(q, 32'hFF);
    rd(8'h40);
    chk(q, 32'h0);
    foreach (rows[i])
    begin
      pre = rows[i].ptr + 21'(rows[i].op[1:0] == 2'h3);
      post = rows[i].op[1:0] == 2'h1 ? pre + 21'h1 :
             rows[i].op[1:0] == 2'h2 ? pre - 21'h1 : pre;
      wr(`TSX_OFS_PTR, 32'(rows[i].ptr));
      wr(`TSX_OFS_LATCH, 32'h50 + 32'(i));
      run(rows[i].op);
      rd(`TSX_OFS_PTR);
      chk(q, 32'(post));
      w = rows[i].op[2] ? 8'h50 + 8'(i) : pm(pre);
      rd(`TSX_OFS_LATCH);
      chk(q, 32'(w));
      chk(32'(bcnt), 32'h8);
      if (rows[i].op[2])
      begin
        rd(`TSX_OFS_HOLD + {3'h0, pre[2:0], 2'h0});
        chk(q, 32'(w));
      end
    end
    foreach (sk[i])
    begin
      ea = sk[i].a ? {sk[i].bank, sk[i].f} :
           (sk[i].ext && sk[i].f <= 8'h5F) ? index_base + 12'(sk[i].f) :
           {(sk[i].f < 8'h60) ? 4'h0 : 4'hF, sk[i].f};
      z = (ea[7:0] ^ {2{ea[11:8]}}) == 8'h00;
      wr(`TSX_OFS_BANK, 32'(sk[i].bank));
      wr(`TSX_OFS_CTRL, 32'(sk[i].ext));
      wr(`TSX_OFS_STATUS, 32'h3);
      next_two_word <= sk[i].two;
      run({7'h33, sk[i].a, sk[i].f});
      rd(`TSX_OFS_STATUS);
      chk(32'(q[2:0]), {29'h0, z, 2'h3});
      chk(32'(faddr), 32'(ea));
      chk(32'(bcnt), z ? (sk[i].two ? 32'hC : 32'h8) : 32'h4);
      chk(32'(scnt), z ? (sk[i].two ? 32'h9 : 32'h5) : 32'h0);
    end
    w = 8'hB5;
    wr(`TSX_OFS_WORK, 32'(w));
    foreach (ks[i])
    begin
      w = w ^ ks[i];
      wr(`TSX_OFS_STATUS, 32'h3);
      run({8'h0A, ks[i]});
      rd(`TSX_OFS_WORK);
      chk(q, 32'(w));
      rd(`TSX_OFS_STATUS);
      chk(32'(q[1:0]), {30'h0, w[7], w == 8'h00});
      chk(32'(bcnt), 32'h4);
    end
    av(1'h1, `TSX_OFS_INSTR, 32'h0A0F);
    wr(`TSX_OFS_WORK, 32'h42);
    rd(`TSX_OFS_WORK);
    chk(q, 32'h42);
    wr(`TSX_OFS_PTR, 32'h5);
    av(1'h1, `TSX_OFS_INSTR, 32'h000C);
    repeat (3) @(posedge ref_clk);
    reset_n <= 1'h0;
    repeat (2) @(posedge ref_clk);
    reset_n <= 1'h1;
    rd(`TSX_OFS_HOLD + 8'h0C);
    chk(q, 32'hFF);
    chk(32'(busy), 32'h0);
    close_out();
  end
endmodule : testbench
`default_nettype wire
